// ===== hdl/wsps_map.svh
// Timing constants for the wheel speed pulse sequencer
`ifndef WSPS_MAP_SVH
`define WSPS_MAP_SVH
`define WSPS_CLK_MHZ 250
`define WSPS_POWERUP_TYP_US 210
`define WSPS_POWERUP_MAX_US 273
`define WSPS_CAL_MAX_US 300
`define WSPS_RESET_MIN_MS 590
`define WSPS_RESET_MAX_MS 848
`define WSPS_STARTUP_WIN_MS 590
`define WSPS_OFFSET_CAL_EDGES 3'h4
`define WSPS_UNCAL_EDGES 3'h4
`define WSPS_POWERUP_CYC (`WSPS_POWERUP_TYP_US * `WSPS_CLK_MHZ)
`define WSPS_CAL_CYC (`WSPS_CAL_MAX_US * `WSPS_CLK_MHZ)
`define WSPS_RESET_CYC (`WSPS_RESET_MIN_MS * 1000 * `WSPS_CLK_MHZ)
`define WSPS_STARTUP_CYC (`WSPS_STARTUP_WIN_MS * 1000 * `WSPS_CLK_MHZ)
`endif

// ===== hdl/wsps_pkg.sv
// Types for the wheel speed pulse sequencer
package wsps_pkg;
    typedef enum logic [1:0] {
        WSPS_POWERUP = 2'h0,
        WSPS_CAL = 2'h1,
        WSPS_UNCAL = 2'h3,
        WSPS_RUN = 2'h2
    } wsps_state_t;
    typedef struct packed {
        logic high_current_level;
        logic calibrated;
        logic operational;
    } wsps_status_t;
endpackage : wsps_pkg

// ===== hdl/wsps_seq.sv
// Start-up, calibration and output sequencing of the speed sensor
// Notes on behaviour
// R1 - The power-up delay ends 210 us after power-up, never later than 273 us; the block becomes operational once calibration follows.
// R2 - Initial calibration lasts at most 300 us and ignores magnetic edges while it runs.
// R3 - Every internal reset is followed by the initial calibration delay before edges count.
// R4 - Offset calibration takes four edges so outputs are placed right from the fifth edge.
// R5 - The first four edges after start run in uncalibrated mode, then calibrated mode follows.
// R6 - No edge is suppressed after power-on or reset once calibration has ended.
// R7 - The first output pulse appears on the first or second edge after reset.
// R8 - After undervoltage or standstill reset the first switch comes within two edges plus calibration delay.
// R9 - With no output switching for the reset interval the block resets itself, once per reset interval plus calibration delay.
// R10 - Standstill triggers a fresh initial calibration every reset interval plus calibration delay.
// R11 - An edge may take up to 590 ms to appear before the start-up attempt lapses.
// R12 - Duty cycle is that of the input edges, since each edge toggles the output.
// R13 - Uncalibrated output edges follow input edges directly, bounding phase error.
// R14 - Only qualified edges, already judged above 3.3 mT by the front end, are counted.
// R15 - The output selects low or high supply current and toggles on each qualified edge.
// R16 - The control unit decodes the two current levels and tolerates missing start-up pulses.
`timescale 1ns/100ps
`include "wsps_map.svh"
module wsps_seq
    import wsps_pkg::*;
#(
    parameter int unsigned POWERUP_CYC = `WSPS_POWERUP_CYC,
    parameter int unsigned CALIB_CYC = `WSPS_CAL_CYC,
    parameter int unsigned RESET_CYC = `WSPS_RESET_CYC,
    parameter int unsigned STARTUP_CYC = `WSPS_STARTUP_CYC
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic undervoltage_in,
    input wire logic mag_edge_in,
    output logic high_current_level_out,
    output wsps_status_t status_out
);
    localparam logic [31:0] PU_CYC = 32'(POWERUP_CYC);
    localparam logic [31:0] CAL_CYC = 32'(CALIB_CYC);
    localparam logic [31:0] RST_CYC = 32'(RESET_CYC);
    localparam logic [31:0] SU_CYC = 32'(STARTUP_CYC);

    // Live states are the only ones in which edges count
    function automatic logic wsps_live(input wsps_state_t s);
        return (s == WSPS_UNCAL) || (s == WSPS_RUN);
    endfunction : wsps_live

    wsps_state_t state_r;
    wsps_state_t state_nxt;
    logic [31:0] phase_cnt_r;
    logic [31:0] idle_cnt_r;
    logic [2:0] edge_cnt_r;
    logic out_r;

    // Any internal reset source
    wire logic int_reset = undervoltage_in || (idle_cnt_r >= RST_CYC - 32'h1);
    wire logic phase_done = (state_r == WSPS_POWERUP) ? (phase_cnt_r >= PU_CYC - 32'h1)
                                                      : (phase_cnt_r >= CAL_CYC - 32'h1);
    // R2 edges ignored
    // R8 first switch window
    // R14 qualified edges only
    wire logic edge_ok = mag_edge_in && wsps_live(state_r);
    wire logic uncal_end = edge_ok && (state_r == WSPS_UNCAL) && (edge_cnt_r == `WSPS_UNCAL_EDGES - 3'h1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            // R1 power-up delay
            WSPS_POWERUP: if (phase_done) state_nxt = WSPS_CAL;
            WSPS_CAL: if (phase_done) state_nxt = WSPS_UNCAL;
            // R4 offset calibration edges
            // R5 uncal to cal
            WSPS_UNCAL: if (uncal_end) state_nxt = WSPS_RUN;
            WSPS_RUN: state_nxt = WSPS_RUN;
            default: state_nxt = WSPS_POWERUP;
        endcase
        // R3 reset recalibrates
        // R10 standstill recalibration
        if (int_reset) begin
            state_nxt = WSPS_CAL;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_r <= WSPS_POWERUP;
            phase_cnt_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            phase_cnt_r <= (state_nxt != state_r || int_reset) ? 32'h0 : phase_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in || int_reset || state_r == WSPS_CAL) begin
            edge_cnt_r <= 3'h0;
        end else if (edge_ok && edge_cnt_r != `WSPS_OFFSET_CAL_EDGES) begin
            edge_cnt_r <= edge_cnt_r + 3'h1;
        end
    end

    // R9 standstill watchdog
    // R11 start-up window
    always_ff @(posedge core_clk_in) begin
        if (reset_in || int_reset || edge_ok || state_r == WSPS_POWERUP || state_r == WSPS_CAL) begin
            idle_cnt_r <= 32'h0;
        end else begin
            idle_cnt_r <= idle_cnt_r + 32'h1;
        end
    end

    // R6 no suppression
    // R7 first edge switches
    // R12 duty follows input
    // R13 direct edge placement
    // R15 current toggle
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            out_r <= 1'b0;
        end else if (edge_ok) begin
            out_r <= ~out_r;
        end
    end

    assign high_current_level_out = out_r;
    assign status_out = '{high_current_level: out_r,
                          calibrated: (state_r == WSPS_RUN),
                          operational: wsps_live(state_r)};

    a_powerup_time: assert property (@(posedge core_clk_in) disable iff (reset_in || undervoltage_in) // R1
        ($fell(state_r == WSPS_POWERUP) && !$past(undervoltage_in)) |-> $past(phase_cnt_r) == PU_CYC - 32'h1)
        else $error("power-up delay length wrong");
    a_cal_ignores_edge: assert property (@(posedge core_clk_in) disable iff (reset_in) // R2
        (state_r == WSPS_CAL && mag_edge_in) |=> $stable(out_r))
        else $error("edge switched output during calibration");
    a_reset_recal: assert property (@(posedge core_clk_in) disable iff (reset_in) // R3
        (undervoltage_in && state_r != WSPS_POWERUP) |=> state_r == WSPS_CAL)
        else $error("internal reset did not restart calibration");
    a_four_uncal_edges: assert property (@(posedge core_clk_in) disable iff (reset_in) // R5
        (state_r == WSPS_UNCAL && state_nxt == WSPS_RUN) |-> edge_cnt_r == 3'h3 && edge_ok)
        else $error("calibrated mode entered on wrong edge");
    a_edge_toggles: assert property (@(posedge core_clk_in) disable iff (reset_in) // R15
        edge_ok |=> out_r != $past(out_r))
        else $error("qualified edge did not toggle output");
    a_watchdog_bound: assert property (@(posedge core_clk_in) disable iff (reset_in) // R9
        idle_cnt_r < RST_CYC)
        else $error("watchdog exceeded reset interval");
    a_no_suppress: assert property (@(posedge core_clk_in) disable iff (reset_in) // R6
        (state_r == WSPS_UNCAL && mag_edge_in && !undervoltage_in) |=> $changed(out_r))
        else $error("first edges suppressed");
    a_startup_window: assert property (@(posedge core_clk_in) disable iff (reset_in) // R11
        (state_r == WSPS_UNCAL && idle_cnt_r == SU_CYC - 32'h1 && !mag_edge_in) |=> state_r == WSPS_CAL)
        else $error("start-up window did not lapse");

    // Phase lengths and calibration
    a_cal_length: assert property (@(posedge core_clk_in) disable iff (reset_in) // R2
        $fell(state_r == WSPS_CAL) |-> $past(phase_cnt_r) == CAL_CYC - 32'h1)
        else $error("calibration delay length wrong");
    a_cal_phase_bound: assert property (@(posedge core_clk_in) disable iff (reset_in) // R2
        (state_r == WSPS_CAL) |-> phase_cnt_r < CAL_CYC)
        else $error("calibration counter overran");
    a_powerup_bound: assert property (@(posedge core_clk_in) disable iff (reset_in) // R1
        (state_r == WSPS_POWERUP) |-> phase_cnt_r < PU_CYC)
        else $error("power-up counter overran");
    a_no_edge_powerup: assert property (@(posedge core_clk_in) disable iff (reset_in) // R2
        (state_r == WSPS_POWERUP && mag_edge_in) |=> $stable(out_r))
        else $error("edge switched output during power-up");
    a_cal_no_count: assert property (@(posedge core_clk_in) disable iff (reset_in) // R2
        (state_r == WSPS_CAL) |=> edge_cnt_r == 3'h0)
        else $error("edge count kept through calibration");
    a_uv_clears_edges: assert property (@(posedge core_clk_in) disable iff (reset_in) // R3
        undervoltage_in |=> edge_cnt_r == 3'h0)
        else $error("undervoltage kept edge count");
    a_operational_gap: assert property (@(posedge core_clk_in) disable iff (reset_in) // R8
        $rose(status_out.operational) |-> $past(state_r) == WSPS_CAL)
        else $error("live state entered without calibration");

    // Edge counting and output switching
    a_uncal_edge_limit: assert property (@(posedge core_clk_in) disable iff (reset_in) // R4
        (state_r == WSPS_UNCAL) |-> edge_cnt_r < `WSPS_UNCAL_EDGES)
        else $error("too many edges in uncalibrated mode");
    a_run_after_four: assert property (@(posedge core_clk_in) disable iff (reset_in) // R4
        $rose(state_r == WSPS_RUN) |-> edge_cnt_r == `WSPS_OFFSET_CAL_EDGES)
        else $error("calibrated mode without four edges");
    a_edge_count_step: assert property (@(posedge core_clk_in) disable iff (reset_in) // R5
        (edge_ok && state_r == WSPS_UNCAL && !int_reset) |=> edge_cnt_r == $past(edge_cnt_r) + 3'h1)
        else $error("uncalibrated edge not counted");
    a_run_stays: assert property (@(posedge core_clk_in) disable iff (reset_in) // R5
        (state_r == WSPS_RUN && !int_reset) |=> state_r == WSPS_RUN)
        else $error("calibrated mode left without reset");
    a_status_calibrated: assert property (@(posedge core_clk_in) disable iff (reset_in) // R5
        status_out.calibrated |-> status_out.operational)
        else $error("calibrated flag without operational flag");
    a_first_edge_switch: assert property (@(posedge core_clk_in) disable iff (reset_in) // R7
        (state_r == WSPS_UNCAL && edge_cnt_r == 3'h0 && mag_edge_in) |=> $changed(high_current_level_out))
        else $error("first edge did not switch output");
    a_duty_follows: assert property (@(posedge core_clk_in) disable iff (reset_in) // R12
        edge_ok |=> high_current_level_out == !$past(high_current_level_out))
        else $error("output level did not follow edge");
    a_run_output_follows: assert property (@(posedge core_clk_in) disable iff (reset_in) // R13
        (state_r == WSPS_RUN && mag_edge_in) |=> $changed(high_current_level_out))
        else $error("calibrated edge did not switch output");
    a_toggle_only_edge: assert property (@(posedge core_clk_in) disable iff (reset_in) // R15
        !edge_ok |=> $stable(high_current_level_out))
        else $error("output switched without qualified edge");

    // Standstill watchdog
    a_idle_clear_edge: assert property (@(posedge core_clk_in) disable iff (reset_in) // R9
        edge_ok |=> idle_cnt_r == 32'h0)
        else $error("edge did not restart watchdog");
    a_idle_frozen_cal: assert property (@(posedge core_clk_in) disable iff (reset_in) // R11
        (state_r == WSPS_CAL) |=> idle_cnt_r == 32'h0)
        else $error("start-up window ran during calibration");
    a_standstill_recal: assert property (@(posedge core_clk_in) disable iff (reset_in) // R10
        (status_out.operational && idle_cnt_r == RST_CYC - 32'h1) |=> state_r == WSPS_CAL && idle_cnt_r == 32'h0)
        else $error("standstill did not recalibrate");
    a_phase_restart: assert property (@(posedge core_clk_in) disable iff (reset_in) // R10
        (state_r == WSPS_RUN && int_reset) |=> phase_cnt_r == 32'h0)
        else $error("recalibration did not restart its timer");

    // Main scenarios
    c_reach_run: cover property (@(posedge core_clk_in) state_r == WSPS_UNCAL ##1 state_r == WSPS_RUN);
    c_undervoltage: cover property (@(posedge core_clk_in) state_r == WSPS_RUN && undervoltage_in);
    c_standstill: cover property (@(posedge core_clk_in) idle_cnt_r == RST_CYC - 32'h1);
    c_cal_done: cover property (@(posedge core_clk_in) state_r == WSPS_CAL ##1 state_r == WSPS_UNCAL);
    c_back_to_back: cover property (@(posedge core_clk_in) edge_ok ##1 edge_ok);
endmodule : wsps_seq

// ===== verification/wheel_speed_pulse_sequencer_tb.sv
// Bench for the wheel speed pulse sequencer
`timescale 1ns/100ps
`include "wsps_map.svh"
module wheel_speed_pulse_sequencer_tb;
    import wsps_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic undervoltage_in = 1'b0;
    logic mag_edge_in = 1'b0;
    logic high_current_level_out;
    wsps_status_t status_out;
    logic [7:0] pulse_count;
    int n_errors = 0;
    int n_tests = 0;
    int wait_cyc;
    localparam int PU_SIM = 40;
    localparam int CAL_SIM = 60;
    logic [1:0] rows [5] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h3};
    always #2 core_clk_in = ~core_clk_in;
    wsps_seq #(.POWERUP_CYC(PU_SIM), .CALIB_CYC(CAL_SIM), .RESET_CYC(200), .STARTUP_CYC(200))
        wsps_seq_i (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .undervoltage_in(undervoltage_in), .mag_edge_in(mag_edge_in),
        .high_current_level_out(high_current_level_out), .status_out(status_out));
    wsps_ecu_model wsps_ecu_model_i (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .high_current_level_in(high_current_level_out), .pulse_count_out(pulse_count));
    task automatic print_verdict();
        $display("Counts: tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic edge_pulse(input int len);
        mag_edge_in = 1'b1;
        repeat (len) @(negedge core_clk_in);
        mag_edge_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
    endtask : edge_pulse
    task automatic wait_op();
        wait_cyc = 0;
        while (status_out.operational !== 1'b1 && wait_cyc < 1000) begin
            @(negedge core_clk_in);
            wait_cyc++;
        end
        if (wait_cyc >= 1000) begin
            n_errors++;
            print_verdict();
        end
    endtask : wait_op
    initial begin
        repeat (10) @(negedge core_clk_in);
        check({status_out, high_current_level_out}, 4'h0);
        check(`WSPS_POWERUP_CYC, 210 * 250);
        check(`WSPS_CAL_CYC, 300 * 250);
        check(`WSPS_RESET_CYC, 590 * 250000);
        reset_in = 1'b0;
        edge_pulse(1);
        wait_op();
        check(wait_cyc + 3, PU_SIM + CAL_SIM);
        check(high_current_level_out, 1'b0);
        $display("Test power-up done");
        for (int i = 0; i < 5; i++) begin
            edge_pulse(1);
            check({status_out.calibrated, high_current_level_out}, rows[i]);
            check(pulse_count, i + 1);
        end
        $display("Test edge rows done");
        edge_pulse(2);
        check({pulse_count, high_current_level_out}, {8'h7, 1'b1});
        $display("Test back-to-back done");
        undervoltage_in = 1'b1;
        @(negedge core_clk_in);
        undervoltage_in = 1'b0;
        edge_pulse(1);
        check({status_out, high_current_level_out}, 4'h9);
        wait_op();
        check(wait_cyc + 3, CAL_SIM);
        edge_pulse(1);
        check({status_out.calibrated, high_current_level_out}, 2'h0);
        $display("Test undervoltage done");
        repeat (190) @(negedge core_clk_in);
        check(status_out.operational, 1'b1);
        repeat (20) @(negedge core_clk_in);
        check({status_out.operational, high_current_level_out}, 2'h0);
        $display("Test standstill done");
        print_verdict();
    end
endmodule : wheel_speed_pulse_sequencer_tb

// ===== verification/wsps_ecu_model.sv
// Control unit model that turns the supply current level into counted pulses
`timescale 1ns/100ps
module wsps_ecu_model (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic high_current_level_in,
    output logic [7:0] pulse_count_out
);
    logic level_r;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            level_r <= 1'b0;
            pulse_count_out <= 8'h0;
        end else begin
            level_r <= high_current_level_in;
            if (level_r != high_current_level_in) begin
                pulse_count_out <= pulse_count_out + 8'h1;
            end
        end
    end
endmodule : wsps_ecu_model
